// [cmpu_core_model.sv]
`timescale 1ns/100ps
// Stands in for the processor core: it drives instruction words and the port latch, and reaches the registers.
module cmpu_core_model (
    input  wire logic                mclk_i,
    input  wire logic [7:0]          rdata_i,
    output cmpu_pkg::cmpu_bus_s      bus_o,
    output logic [13:0]              instr_o,
    output logic                     port_latch_o
);
    import cmpu_pkg::*;

    initial begin
        bus_o        = '0;
        instr_o      = 14'h2000;
        port_latch_o = 1'b0;
    end

    // The address is inverted on release so that no stale value looks valid.
    task automatic wr_reg(input cmpu_byte_t addr, input cmpu_byte_t data);
        @(posedge mclk_i);
        bus_o.addr  <= addr;
        bus_o.wdata <= data;
        bus_o.wr    <= 1'b1;
        @(posedge mclk_i);
        bus_o.wr    <= 1'b0;
        bus_o.addr  <= ~addr;
        bus_o.wdata <= ~data;
        // Returning mid-cycle lets callers look at outputs once the write edge has settled.
        @(negedge mclk_i);
    endtask : wr_reg

    task automatic rd_reg(input cmpu_byte_t addr, output cmpu_byte_t data);
        @(posedge mclk_i);
        bus_o.addr <= addr;
        bus_o.rd   <= 1'b1;
        @(posedge mclk_i);
        bus_o.rd   <= 1'b0;
        bus_o.addr <= ~addr;
        @(negedge mclk_i);
        data = rdata_i;
    endtask : rd_reg

    task automatic drive(input logic [13:0] ins, input logic latch);
        @(posedge mclk_i);
        instr_o      <= ins;
        port_latch_o <= latch;
    endtask : drive
endmodule : cmpu_core_model

// [cmpu_pkg.sv]
package cmpu_pkg;
    localparam int unsigned INSTR_W   = 14;
    localparam int unsigned INSTR_MSB = 13;
    localparam int unsigned LIT_W     = 8;
    localparam int unsigned MODE_W    = 4;

    typedef logic [7:0]  cmpu_byte_t;
    typedef logic [15:0] cmpu_word_t;

    localparam cmpu_byte_t ADDR_ISTAT  = 8'h0C;
    localparam cmpu_byte_t ADDR_IMASK  = 8'h0D;
    localparam cmpu_byte_t ADDR_TMR_LO = 8'h0E;
    localparam cmpu_byte_t ADDR_TMR_HI = 8'h0F;
    localparam cmpu_byte_t ADDR_TCTRL  = 8'h10;
    localparam cmpu_byte_t ADDR_CMP_LO = 8'h15;
    localparam cmpu_byte_t ADDR_CMP_HI = 8'h16;
    localparam cmpu_byte_t ADDR_CTRL   = 8'h17;

    localparam cmpu_byte_t BYTE_ZERO = 8'h00;
    localparam cmpu_byte_t BYTE_ONES = 8'hFF;
    localparam cmpu_byte_t BYTE_ONE  = 8'h01;
    localparam cmpu_word_t WORD_ZERO = 16'h0000;
    localparam cmpu_word_t WORD_ONE  = 16'h0001;
    localparam cmpu_word_t WORD_MAX  = 16'hFFFF;

    localparam int unsigned TC_RUN_BIT = 0;
    localparam int unsigned TC_ADC_BIT = 1;
    localparam int unsigned IRQ_CMP    = 0;
    localparam int unsigned IRQ_OVF    = 1;
    localparam int unsigned IRQ_W      = 2;

    localparam logic [MODE_W-1:0] MODE_CMP_HIGH = 4'h8;
    localparam logic [MODE_W-1:0] MODE_CMP_LOW  = 4'h9;
    localparam logic [MODE_W-1:0] MODE_CMP_SOFT = 4'hA;
    localparam logic [MODE_W-1:0] MODE_CMP_SEV  = 4'hB;
    localparam logic [1:0]        MODE_CMP_TOP  = 2'h2;

    typedef struct packed {
        cmpu_byte_t addr;
        cmpu_byte_t wdata;
        logic       wr;
        logic       rd;
    } cmpu_bus_s;

    function automatic logic cmpu_is_compare(input logic [MODE_W-1:0] mode);
        return mode[MODE_W-1 -: 2] == MODE_CMP_TOP;
    endfunction : cmpu_is_compare

    function automatic logic cmpu_is_cmp_addr(input cmpu_byte_t lit);
        return (lit == ADDR_CMP_LO) || (lit == ADDR_CMP_HI) || (lit == ADDR_CTRL);
    endfunction : cmpu_is_cmp_addr
endpackage : cmpu_pkg

// [cmpu_top.sv]
`timescale 1ns/100ps
// Summary of operation
// - Entering drive-low mode from a non-compare mode forces the pin low at once.
// - In drive-low mode the pin is driven low when the match occurs.
// - Entering drive-high mode from any other mode forces the pin low at once.
// - In drive-high mode the pin goes high on the match.
// - Trigger is dropped if prior literal hits a compare address and current MSB is zero.
// - The compare interrupt is raised even when the trigger is dropped.
// - The trigger clears the timer and, when enabled, starts a conversion.
// - After run then stop, writing the timer high byte bumps the low byte.
// - After run then stop, writing low byte while it holds all ones bumps the high byte.
module cmpu_top (
    input  wire logic               mclk_i,
    input  wire logic               rst_n_i,
    input  wire cmpu_pkg::cmpu_bus_s bus_i,
    output logic [7:0]              rdata_o,
    input  wire logic [13:0]        instr_i,
    input  wire logic               port_latch_i,
    output logic                    pin_o,
    output logic                    special_event_o,
    output logic                    adc_start_o,
    output logic                    irq_o
);
    import cmpu_pkg::*;

    cmpu_byte_t          cmp_lo_q;
    cmpu_byte_t          cmp_hi_q;
    cmpu_byte_t          ctrl_q;
    cmpu_byte_t          tctrl_q;
    cmpu_word_t          tmr_q;
    logic                stale_q;
    logic [IRQ_W-1:0]    istat_q;
    logic [IRQ_W-1:0]    imask_q;
    logic                pin_q;
    logic                eq_q;
    logic [INSTR_W-1:0]  instr_q;
    cmpu_byte_t          rdata_q;
    logic                sev_q;
    logic                adc_q;

    logic [MODE_W-1:0]   mode;
    logic [MODE_W-1:0]   new_mode;
    logic                wr_ctrl;
    logic                wr_tlo;
    logic                wr_thi;
    logic                wr_tctrl;
    logic                trun;
    logic                tmr_eq;
    logic                match;
    logic                lit_hit;
    logic                suppress;
    logic                special;
    logic                ovf;
    logic [IRQ_W-1:0]    irq_set;
    logic [IRQ_W-1:0]    irq_clr;

    assign mode     = ctrl_q[MODE_W-1:0];
    assign new_mode = bus_i.wdata[MODE_W-1:0];
    assign wr_ctrl  = bus_i.wr && (bus_i.addr == ADDR_CTRL);
    assign wr_tlo   = bus_i.wr && (bus_i.addr == ADDR_TMR_LO);
    assign wr_thi   = bus_i.wr && (bus_i.addr == ADDR_TMR_HI);
    assign wr_tctrl = bus_i.wr && (bus_i.addr == ADDR_TCTRL);
    assign trun     = tctrl_q[TC_RUN_BIT];

    // A stopped timer sitting on the compare value must not match every cycle, so only the
    // first cycle of equality counts.
    assign tmr_eq   = (tmr_q == {cmp_hi_q, cmp_lo_q});
    assign match    = cmpu_is_compare(mode) && tmr_eq && !eq_q;

    assign lit_hit  = cmpu_is_cmp_addr(instr_q[LIT_W-1:0]);
    assign suppress = lit_hit && !instr_i[INSTR_MSB];
    assign special  = match && (mode == MODE_CMP_SEV) && !suppress;
    assign ovf      = trun && (tmr_q == WORD_MAX);

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmp_lo_q <= BYTE_ZERO;
            cmp_hi_q <= BYTE_ZERO;
            ctrl_q   <= BYTE_ZERO;
            tctrl_q  <= BYTE_ZERO;
            imask_q  <= '0;
        end else if (bus_i.wr) begin
            case (bus_i.addr)
                ADDR_CMP_LO: cmp_lo_q <= bus_i.wdata;
                ADDR_CMP_HI: cmp_hi_q <= bus_i.wdata;
                ADDR_CTRL:   ctrl_q   <= bus_i.wdata;
                ADDR_TCTRL:  tctrl_q  <= bus_i.wdata;
                ADDR_IMASK:  imask_q  <= bus_i.wdata[IRQ_W-1:0];
                default:     ;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            instr_q <= '0;
            eq_q    <= 1'b0;
        end else begin
            instr_q <= instr_i;
            eq_q    <= tmr_eq;
        end
    end

    // Mode changes take effect on the same edge as the control write; a match in that cycle
    // yields to the mode change.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_q <= 1'b0;
        end else if (wr_ctrl && (new_mode != mode)) begin
            if (new_mode == MODE_CMP_HIGH) begin
                pin_q <= 1'b0;
            end else if ((new_mode == MODE_CMP_LOW) && (mode != MODE_CMP_HIGH)) begin
                pin_q <= 1'b0;
            end
        end else if (match && (mode == MODE_CMP_HIGH)) begin
            pin_q <= 1'b1;
        end else if (match && (mode == MODE_CMP_LOW)) begin
            pin_q <= 1'b0;
        end else if (!cmpu_is_compare(mode)) begin
            pin_q <= port_latch_i;
        end
    end

    // The byte-write side effects are kept deterministic so that tests can rely on them.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tmr_q <= WORD_ZERO;
        end else if (special) begin
            tmr_q <= WORD_ZERO;
        end else if (wr_thi) begin
            tmr_q[15:8] <= bus_i.wdata;
            if (stale_q) begin
                tmr_q[7:0] <= tmr_q[7:0] + BYTE_ONE;
            end
        end else if (wr_tlo) begin
            tmr_q[7:0] <= bus_i.wdata;
            if (stale_q && (tmr_q[7:0] == BYTE_ONES)) begin
                tmr_q[15:8] <= tmr_q[15:8] + BYTE_ONE;
            end
        end else if (trun) begin
            tmr_q <= tmr_q + WORD_ONE;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stale_q <= 1'b0;
        end else if (wr_tctrl) begin
            if (bus_i.wdata[TC_RUN_BIT]) begin
                stale_q <= 1'b0;
            end else if (trun) begin
                stale_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sev_q <= 1'b0;
            adc_q <= 1'b0;
        end else begin
            sev_q <= special;
            adc_q <= special && tctrl_q[TC_ADC_BIT];
        end
    end

    // A byte write that wraps the timer does not count as an overflow.
    assign irq_set[IRQ_CMP] = match;
    assign irq_set[IRQ_OVF] = ovf && !special && !wr_thi && !wr_tlo;
    assign irq_clr = (bus_i.wr && (bus_i.addr == ADDR_ISTAT)) ? bus_i.wdata[IRQ_W-1:0] : '0;

    // Set wins over the write-one clear.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            istat_q <= '0;
        end else begin
            istat_q <= (istat_q & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= BYTE_ZERO;
        end else if (bus_i.rd) begin
            case (bus_i.addr)
                ADDR_CMP_LO: rdata_q <= cmp_lo_q;
                ADDR_CMP_HI: rdata_q <= cmp_hi_q;
                ADDR_CTRL:   rdata_q <= ctrl_q;
                ADDR_TCTRL:  rdata_q <= tctrl_q;
                ADDR_TMR_LO: rdata_q <= tmr_q[7:0];
                ADDR_TMR_HI: rdata_q <= tmr_q[15:8];
                ADDR_ISTAT:  rdata_q <= {6'h00, istat_q};
                ADDR_IMASK:  rdata_q <= {6'h00, imask_q};
                default:     rdata_q <= BYTE_ZERO;
            endcase
        end else begin
            rdata_q <= BYTE_ZERO;
        end
    end

    assign rdata_o         = rdata_q;
    assign pin_o           = pin_q;
    assign special_event_o = sev_q;
    assign adc_start_o     = adc_q;
    assign irq_o           = |(istat_q & imask_q);

    AST_ENTER_LOW: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        wr_ctrl && (new_mode == MODE_CMP_LOW) && !cmpu_is_compare(mode) |=> !pin_o)
        else $error("pin not forced low on entry to drive-low mode");

    AST_LOW_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (mode == MODE_CMP_LOW) && !pin_o && !bus_i.wr ##1 match && !bus_i.wr |=> !pin_o [*2])
        else $error("pin left low state in drive-low mode");

    AST_ENTER_HIGH: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        wr_ctrl && (new_mode == MODE_CMP_HIGH) && (mode != MODE_CMP_HIGH) |=> !pin_o)
        else $error("pin not forced low on entry to drive-high mode");

    AST_MATCH_HIGH: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (mode == MODE_CMP_HIGH) && match && !wr_ctrl |=> pin_o)
        else $error("pin not raised on match in drive-high mode");

    AST_SUPPRESS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        match && (mode == MODE_CMP_SEV) && cmpu_is_cmp_addr($past(instr_i[LIT_W-1:0]))
        && !instr_i[INSTR_MSB] |=> !special_event_o && (tmr_q != WORD_ZERO || !trun))
        else $error("special trigger fired although suppressed");

    AST_IRQ_STILL: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        match && suppress |=> istat_q[IRQ_CMP] && !special_event_o)
        else $error("compare interrupt missing on suppressed trigger");

    AST_SEV_RESET: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        special |=> special_event_o && (tmr_q == WORD_ZERO) && (adc_start_o == tctrl_q[TC_ADC_BIT]))
        else $error("special trigger did not clear timer");

    AST_HI_BUMP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        wr_thi && stale_q && !special |=> tmr_q[7:0] == $past(tmr_q[7:0]) + BYTE_ONE)
        else $error("low byte not bumped on high byte write");

    AST_LO_CARRY: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        wr_tlo && stale_q && (tmr_q[7:0] == BYTE_ONES) && !special
        |=> tmr_q[15:8] == $past(tmr_q[15:8]) + BYTE_ONE)
        else $error("high byte not bumped on low byte write");

    AST_MATCH_DEF: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        cmpu_is_compare(mode) && $rose(tmr_eq) |=> istat_q[IRQ_CMP])
        else $error("equal timer and compare value gave no interrupt");

    CV_HIGH_MATCH: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        (mode == MODE_CMP_HIGH) && match ##1 pin_o);
    CV_SEV: cover property (@(posedge mclk_i) disable iff (!rst_n_i) special ##1 adc_start_o);
    CV_SUPPRESS: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        match && (mode == MODE_CMP_SEV) && suppress);
    CV_LO_CARRY: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        wr_tlo && stale_q && (tmr_q[7:0] == BYTE_ONES));
endmodule : cmpu_top

// [testbench.sv]
`timescale 1ns/100ps
module testbench;
    import cmpu_pkg::*;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    cmpu_bus_s   bus;
    logic [7:0]  rdata;
    logic [13:0] instr;
    logic        latch, pin, sev, adc, irq;
    int          num_errors = 0;
    int          checks_done = 0;
    cmpu_byte_t  rv;

    always #12.5 mclk = ~mclk;

    cmpu_top cmpu_top_i (.mclk_i(mclk), .rst_n_i(rst_n), .bus_i(bus), .rdata_o(rdata), .instr_i(instr),
        .port_latch_i(latch), .pin_o(pin), .special_event_o(sev), .adc_start_o(adc), .irq_o(irq));
    cmpu_core_model cmpu_core_model_i (.mclk_i(mclk), .rdata_i(rdata), .bus_o(bus), .instr_o(instr),
        .port_latch_o(latch));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic restart(input logic [13:0] ins, input logic lat);
        @(posedge mclk);
        rst_n <= 1'b0;
        cmpu_core_model_i.drive(ins, lat);
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
    endtask : restart

    task automatic reg_access();
        restart(14'h2000, 1'b0);
        cmpu_core_model_i.rd_reg(ADDR_CTRL, rv);
        check(rv, 8'h00);
        cmpu_core_model_i.wr_reg(ADDR_CMP_LO, 8'hA5);
        cmpu_core_model_i.wr_reg(ADDR_CMP_HI, 8'h5A);
        cmpu_core_model_i.wr_reg(ADDR_CTRL, 8'h0B);
        cmpu_core_model_i.rd_reg(ADDR_CMP_LO, rv);
        check(rv, 8'hA5);
        cmpu_core_model_i.rd_reg(ADDR_CMP_HI, rv);
        check(rv, 8'h5A);
        cmpu_core_model_i.rd_reg(ADDR_CTRL, rv);
        check(rv, 8'h0B);
        cmpu_core_model_i.rd_reg(8'h20, rv);
        check(rv, 8'h00);
    endtask : reg_access

    task automatic drive_high();
        int n;
        restart(14'h2000, 1'b1);
        check(pin, 1'b1);
        cmpu_core_model_i.wr_reg(ADDR_CMP_LO, 8'h20);
        cmpu_core_model_i.wr_reg(ADDR_CTRL, 8'h08);
        check(pin, 1'b0);
        cmpu_core_model_i.wr_reg(ADDR_TCTRL, 8'h01);
        for (n = 0; n < 80 && pin !== 1'b1; n++) @(negedge mclk);
        check(pin, 1'b1);
        check(16'(n), 16'h0021);
        check(irq, 1'b0);
        cmpu_core_model_i.wr_reg(ADDR_IMASK, 8'h01);
        check(irq, 1'b1);
        // Moving from drive-high to drive-low keeps the pin high until the next match.
        cmpu_core_model_i.wr_reg(ADDR_CTRL, 8'h09);
        check(pin, 1'b1);
        cmpu_core_model_i.wr_reg(ADDR_ISTAT, 8'h01);
        cmpu_core_model_i.rd_reg(ADDR_ISTAT, rv);
        check(rv, 8'h00);
        check(irq, 1'b0);
        // Restarting the count from zero brings the next match, which now takes the pin low.
        cmpu_core_model_i.wr_reg(ADDR_TMR_LO, 8'h00);
        for (n = 0; n < 80 && pin !== 1'b0; n++) @(negedge mclk);
        check(pin, 1'b0);
        check(16'(n), 16'h0021);
    endtask : drive_high

    task automatic drive_low();
        restart(14'h2000, 1'b1);
        check(pin, 1'b1);
        cmpu_core_model_i.wr_reg(ADDR_CMP_LO, 8'h20);
        cmpu_core_model_i.wr_reg(ADDR_IMASK, 8'h01);
        cmpu_core_model_i.wr_reg(ADDR_CTRL, 8'h09);
        check(pin, 1'b0);
        cmpu_core_model_i.wr_reg(ADDR_TCTRL, 8'h01);
        for (int i = 0; i < 80 && irq !== 1'b1; i++) @(negedge mclk);
        check(irq, 1'b1);
        check(pin, 1'b0);
    endtask : drive_low

    task automatic arm_trigger(input logic [13:0] ins);
        restart(ins, 1'b0);
        cmpu_core_model_i.wr_reg(ADDR_CMP_LO, 8'h20);
        cmpu_core_model_i.wr_reg(ADDR_CTRL, 8'h0B);
        cmpu_core_model_i.wr_reg(ADDR_TCTRL, 8'h03);
    endtask : arm_trigger

    task automatic trigger_fires();
        arm_trigger(14'h2000);
        for (int i = 0; i < 80 && sev !== 1'b1; i++) @(negedge mclk);
        check(sev, 1'b1);
        check(adc, 1'b1);
        @(negedge mclk);
        check(sev, 1'b0);
        cmpu_core_model_i.rd_reg(ADDR_TMR_HI, rv);
        check(rv, 8'h00);
        cmpu_core_model_i.rd_reg(ADDR_TMR_LO, rv);
        check(rv, 8'h04);
    endtask : trigger_fires

    // The literal stays on the instruction bus so it covers the cycle before the match.
    // The last pass keeps the literal but sets the top bit, so the trigger must fire once.
    task automatic trigger_dropped();
        int pulses;
        for (int k = 0; k < 4; k++) begin
            arm_trigger((k < 3) ? 14'h0015 + 14'(k) : 14'h2015);
            pulses = 0;
            repeat (40) begin
                @(negedge mclk);
                pulses += int'(sev === 1'b1);
            end
            check(16'(pulses), (k < 3) ? 16'h0000 : 16'h0001);
            cmpu_core_model_i.rd_reg(ADDR_ISTAT, rv);
            check(rv & 8'h01, 8'h01);
        end
    endtask : trigger_dropped

    task automatic timer_writes();
        cmpu_byte_t lo;
        cmpu_byte_t hi;
        restart(14'h2000, 1'b0);
        cmpu_core_model_i.wr_reg(ADDR_TCTRL, 8'h01);
        cmpu_core_model_i.wr_reg(ADDR_TCTRL, 8'h00);
        cmpu_core_model_i.rd_reg(ADDR_TMR_LO, lo);
        cmpu_core_model_i.wr_reg(ADDR_TMR_HI, 8'h3F);
        cmpu_core_model_i.rd_reg(ADDR_TMR_LO, rv);
        check(rv, lo + 8'h01);
        cmpu_core_model_i.wr_reg(ADDR_TMR_LO, 8'hFF);
        cmpu_core_model_i.wr_reg(ADDR_TMR_LO, 8'h00);
        cmpu_core_model_i.rd_reg(ADDR_TMR_HI, rv);
        check(rv, 8'h40);
        cmpu_core_model_i.rd_reg(ADDR_TMR_LO, rv);
        check(rv, 8'h00);
        cmpu_core_model_i.rd_reg(ADDR_ISTAT, rv);
        check(rv & 8'h02, 8'h00);
        // Shadow update: copy both bytes, change the copy, write high first and low last,
        // so the low write repairs the bump that the high write caused.
        cmpu_core_model_i.rd_reg(ADDR_TMR_HI, hi);
        cmpu_core_model_i.rd_reg(ADDR_TMR_LO, lo);
        cmpu_core_model_i.wr_reg(ADDR_TMR_HI, hi + 8'h01);
        cmpu_core_model_i.wr_reg(ADDR_TMR_LO, lo);
        cmpu_core_model_i.rd_reg(ADDR_TMR_HI, rv);
        check(rv, 8'h41);
        cmpu_core_model_i.rd_reg(ADDR_TMR_LO, rv);
        check(rv, 8'h00);
    endtask : timer_writes

    initial begin
        repeat (4000) @(posedge mclk);
        num_errors++;
        test_done();
    end

    initial begin
        reg_access();
        drive_high();
        drive_low();
        trigger_fires();
        trigger_dropped();
        timer_writes();
        test_done();
    end
endmodule : testbench
